// [dv/ebcl_mem_model.sv]
// Behavioural serial EEPROM that answers the loader on the two-wire link.
`timescale 1ns/1ps
`default_nettype none
module ebcl_mem_model (
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic [2:0] dev,
    input  wire logic       nack_all,
    output logic            pull
);
    logic [7:0]  mem [65536];  // Image, loaded by the bench.
    logic [7:0]  sh;           // Byte being shifted.
    logic [15:0] adr;          // Address pointer.
    int          bn = 0;       // Bit number in the byte.
    int          st = 4;       // 0 ctrl, 1 high, 2 low, 3 read, 4 idle, 5 wait.
    initial pull = 1'b0;
    // A start restarts decoding and a stop idles the model.
    always @(sda) if (scl) begin
        st = sda ? 4 : 0;
        bn = -1;
    end
    // Written bits shift in; a high acknowledge ends a read.
    always @(posedge scl) if (st == 3 && bn == 8 && sda) st = 4;
        else if (st != 3 && bn < 8) sh = {sh[6:0], sda};
    // Answers change only while the clock is low, so they never look like a start or stop.
    always @(negedge scl) if (st != 4) begin
        bn = bn + 1;
        if (bn == 8 && st != 3) begin
            pull = !nack_all && (st != 0 || sh[7:1] == {4'ha, dev});
            st = !pull ? 4 : st == 0 ? (sh[0] ? 3 : 1) : st == 1 ? 2 : 5;
            adr = st == 2 ? {sh, adr[7:0]} : st == 5 ? {adr[15:8], sh} : adr;
        end else if (bn == 9) begin
            bn = 0;
            if (st == 3) sh = mem[adr];
            if (st == 3) adr = adr + 16'h1;
            pull = st == 3 && !sh[7];
        end else pull = st == 3 && bn < 8 && !sh[7 - bn];
    end
endmodule  // ebcl_mem_model
`default_nettype wire

// [dv/tb.sv]
// Self-checking bench for the boot configuration loader.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ebcl_pkg::*;
    logic        mclk = 1'b0;
    logic        resetn = 1'b0;
    logic [2:0]  rid = 3'h0;     // Strapped record ID.
    logic [2:0]  dev = 3'h5;     // Strapped slave bits.
    logic        absent = 1'b0;  // No memory, line tied low.
    logic        nack = 1'b0;    // Memory answers nothing.
    logic [1:0]  sz = 2'h0;      // Strapped scan size.
    logic        pull, sda_oe, scl_oe, sda_o, scl_o, done, present, fw_hold, wr_v;
    logic [4:0]  station;
    logic [7:0]  wr_a;
    logic [15:0] wr_d;
    logic [23:0] exp_q [$];      // Expected configuration writes.
    int          error_cnt = 0;
    int          compares = 0;
    int          seed = 32'h02e67b25;
    // Open-drain wires: an enabled pin shows the level it drives, otherwise the pull-up wins.
    wire         sda_w = (sda_oe ? sda_o : 1'b1) && !pull && !absent;
    wire         scl_w = scl_oe ? scl_o : 1'b1;
    initial forever #20 mclk = !mclk;
    ebcl_loader #(.PROBE_TIMEOUT(2000)) i_dut (.mclk(mclk), .resetn(resetn), .sda_in(sda_w), .sda_out(sda_o),
        .sda_oe(sda_oe), .scl_out(scl_o), .scl_oe(scl_oe), .strap_speed(SPEED_HIGH), .strap_addr_mode(1'b1),
        .strap_dev_addr(dev), .strap_record_id(rid), .strap_scan_size(sz), .eeprom_present(present),
        .load_done(done), .station_address(station), .cfg_wr_valid(wr_v), .cfg_wr_addr(wr_a),
        .cfg_wr_data(wr_d), .fw_hold(fw_hold));
    ebcl_mem_model i_mem (.scl(scl_w), .sda(sda_w), .dev(dev), .nack_all(nack), .pull(pull));
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("compares %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    function automatic logic [7:0] m(input int a);
        return i_mem.mem[a[15:0]];
    endfunction
    // Places a signature record; the reserved pair is all ones as the image demands.
    task automatic put(input int a, input logic [2:0] id, input logic [15:0] ptr);
        logic [79:0] r;
        r = {32'heec0de1f, 5'h0, id, 3'h0, 5'($random(seed)), ptr, 16'hffff};
        for (int j = 0; j < 10; j++) i_mem.mem[a + j] = r[79 - 8 * j -: 8];
    endtask
    // Per-cycle checks on the falling edge, where the registered outputs have settled.
    always @(negedge mclk) if (resetn) begin
        chk(fw_hold, !done);
        if (!done) chk(station, 5'h0);
        if (wr_v) chk({wr_a, wr_d}, exp_q.size() > 0 ? exp_q.pop_front() : 24'hx);
    end
    // One boot: random image with decoys, reset, reference scan, then the final state.
    task automatic run(input logic ab, input logic nk, input int slot, input logic [15:0] ptr, input int n);
        logic [4:0] st;
        int         i, k, p, s;
        @(posedge mclk);
        #2 resetn = 1'b0;
        absent = ab;
        nack = nk;
        rid = 3'($random(seed));
        sz = 2'($random(seed));
        s = (256 << (sz + 4)) / 64;  // Wide mode range split into 64 slots.
        for (i = 0; i < 65536; i++) i_mem.mem[i] = 8'($random(seed));
        put(slot * s - s, ~rid, ptr);
        put(slot * s - s / 2, rid, ptr);
        put(slot * s, rid, ptr);
        i_mem.mem[ptr] = 8'(n - 1);
        repeat (20) @(posedge mclk);
        #2 resetn = 1'b1;
        st = {2'h0, rid};
        exp_q.delete();
        for (k = 0; k < 64 && !ab && !nk; k++) begin
            p = k * s;
            if ({m(p), m(p + 1), m(p + 2), m(p + 3), m(p + 4)} === {32'heec0de1f, 5'h0, rid}) begin
                st = 5'(m(p + 5));
                p = {m(p + 6), m(p + 7)};
                for (i = 0; p != 65535 && i <= m(p); i++) exp_q.push_back({m(p+3*i+1), m(p+3*i+2), m(p+3*i+3)});
                k = 64;
            end
        end
        for (i = 0; i < 75000 && done !== 1'b1; i++) @(posedge mclk);
        repeat (3) @(posedge mclk);
        chk({i < 75000, present, station, exp_q.size() == 0}, {1'b1, !ab && !nk, st, 1'b1});
        $display("boot ended: slot %0d, pointer %h, entries %0d", slot, ptr, n);
    endtask
    initial begin
        #(40 * 130000);
        error_cnt++;
        results();
    end
    initial begin
        run(1'b1, 1'b0, 2, 16'hffff, 1);
        run(1'b0, 1'b1, 2, 16'hffff, 1);
        run(1'b0, 1'b0, 5, 16'hf000, 1);
        run(1'b0, 1'b0, 20, 16'h0900, 2 + $unsigned($random(seed)) % 7);
        run(1'b0, 1'b0, 3, 16'hffff, 4);
        run(1'b0, 1'b0, 64, 16'h0a00, 3);
        results();
    end
endmodule  // tb
`default_nettype wire

// [rtl/ebcl_loader.sv]
// Start-up loader: detects, probes and scans a serial EEPROM, then loads configuration.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1 - Sense data line after reset: high means fitted.
// R2 - Boards without memory tie data line low.
// R3 - Straps set speed, address mode, slave bits.
// R4 - Probe read; no acknowledge by time-out aborts.
// R5 - Memory must acknowledge within the time-out.
// R6 - Search signature EE C0 DE 1F in order.
// R7 - Test only stride multiples; stride is range/64.
// R8 - Scan miss stops all further memory reads.
// R9 - Station address zero until record read.
// R10 - Offset 4 record ID must match strap.
// R11 - Offset 5 gives five-bit station address.
// R12 - No record: station is zeros plus record ID.
// R13 - Offsets 6,7 content pointer; all-ones means none.
// R14 - Image holds all-ones at offsets 8, 9.
// R15 - Load matching record right after reset.
// R16 - Copy content before controller runs it.
// R17 - Count byte plus three-byte entries follow.
// R18 - Seven-bit slave address, fixed top four bits.
// R19 - Probe time-out is a cycle-count parameter.
module ebcl_loader
    import ebcl_pkg::*;
#(
    parameter int PROBE_TIMEOUT = PROBE_TIMEOUT_CYC  // Probe acknowledge wait in core cycles.
) (
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    output logic             scl_out,
    output logic             scl_oe,
    input  wire logic [1:0]  strap_speed,
    input  wire logic        strap_addr_mode,
    input  wire logic [2:0]  strap_dev_addr,
    input  wire logic [2:0]  strap_record_id,
    input  wire logic [1:0]  strap_scan_size,
    output logic             eeprom_present,
    output logic             load_done,
    output logic [4:0]       station_address,
    output logic             cfg_wr_valid,
    output logic [7:0]       cfg_wr_addr,
    output logic [15:0]      cfg_wr_data,
    output logic             fw_hold
);
    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and strap capture.
    logic              sda_meta_reg, sda_sync_reg;   // Data line, two flops.
    logic [10:0]       strap_meta_reg, strap_sync_reg; // Strap pins, two flops.
    logic [10:0]       strap_reg;                    // Straps caught at detection.
    wire  [1:0]        st_speed = strap_reg[10:9];
    wire               st_mode  = strap_reg[8];
    wire  [2:0]        st_dev   = strap_reg[7:5];
    wire  [2:0]        st_id    = strap_reg[4:2];
    wire  [1:0]        st_size  = strap_reg[1:0];

    // Straps are static, so a plain two-flop bundle is safe here.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sda_meta_reg   <= 1'b0;
            sda_sync_reg   <= 1'b0;
            strap_meta_reg <= '0;
            strap_sync_reg <= '0;
        end else begin
            sda_meta_reg   <= sda_in;
            sda_sync_reg   <= sda_meta_reg;
            strap_meta_reg <= {strap_speed, strap_addr_mode, strap_dev_addr, strap_record_id, strap_scan_size};
            strap_sync_reg <= strap_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Serial link engine: one transaction is a random read of rem bytes.
    ebcl_lk_e          lk_reg, lk_next;
    logic [7:0]        tx_next;
    logic [1:0]        q_reg;          // Quarter within a bit.
    logic [QTR_W-1:0]  qcnt_reg;       // Quarter divider, gives the enable pulse.
    logic [3:0]        bit_reg;        // Bit within a byte, 8 is acknowledge.
    logic [7:0]        tx_reg, rx_reg;
    logic              ack_ok_reg;     // Last acknowledge seen from the memory.
    logic [9:0]        rem_reg;        // Bytes left to read.
    logic [9:0]        bcnt_reg;       // Bytes read so far.
    logic              txn_done_reg, txn_nack_reg, byte_stb_reg;
    logic              sda_out_reg, scl_out_reg;
    // Loader state used by the engine.
    ebcl_ld_e          ld_reg;
    logic              go_reg;
    logic [15:0]       job_addr_reg;
    logic [9:0]        job_len_reg;

    // Control byte: fixed nibble, strap bits OR'ed with high address bits in narrow mode.
    function automatic logic [7:0] ctrl_byte(input logic [2:0] dev, input logic [2:0] ahi,
                                             input logic m16, input logic rd);
        return {SLAVE_FIXED, dev | (m16 ? 3'h0 : ahi), rd};  // see R18 see R3
    endfunction

    // The divider runs down to zero inclusive, so it is reloaded with one less than the quarter length.
    wire  [QTR_W-1:0] qtr_load = (st_speed == SPEED_STD)  ? QTR_W'(qtr_cycles(SCL_STD_KHZ) - 1)  :
                                 (st_speed == SPEED_FAST) ? QTR_W'(qtr_cycles(SCL_FAST_KHZ) - 1) :
                                 (st_speed == SPEED_MEGA) ? QTR_W'(qtr_cycles(SCL_MEGA_KHZ) - 1) :
                                                            QTR_W'(qtr_cycles(SCL_HIGH_KHZ) - 1);  // see R3
    wire  [7:0] ctrl_w  = ctrl_byte(st_dev, job_addr_reg[10:8], st_mode, 1'b0);
    wire  [7:0] ctrl_r  = ctrl_byte(st_dev, job_addr_reg[10:8], st_mode, 1'b1);
    wire        is_wr   = (lk_reg == LK_CTRLW) || (lk_reg == LK_ADRH) || (lk_reg == LK_ADRL) ||
                          (lk_reg == LK_CTRLR);
    // The count byte of a content record sets the length of the rest.
    wire        cnt_first = (ld_reg == LD_CONTENT) && (bcnt_reg == 10'h0);  // see R17
    wire        read_last = (rem_reg == 10'h1) && !cnt_first;
    wire        sda_drive = (lk_reg == LK_STOP) ? 1'b1 :
                            is_wr ? ((bit_reg != ACK_BIT) && !tx_reg[7]) :
                            (lk_reg == LK_READ) ? ((bit_reg == ACK_BIT) && !read_last) : 1'b0;
    wire  [9:0] rem_new = cnt_first ? 10'(ENTRY_BYTES) * (10'(rx_reg) + 10'h1) : rem_reg - 10'h1;

    // Byte-level sequence; any missing acknowledge ends the transaction with a stop.
    always_comb begin
        lk_next = LK_IDLE;
        tx_next = 8'h00;
        unique case (lk_reg)
            LK_START:  begin lk_next = LK_CTRLW; tx_next = ctrl_w; end
            LK_CTRLW:  begin
                lk_next = !ack_ok_reg ? LK_STOP : (st_mode ? LK_ADRH : LK_ADRL);
                tx_next = st_mode ? job_addr_reg[15:8] : job_addr_reg[7:0];
            end
            LK_ADRH:   begin lk_next = ack_ok_reg ? LK_ADRL : LK_STOP; tx_next = job_addr_reg[7:0]; end
            LK_ADRL:   lk_next = ack_ok_reg ? LK_RSTART : LK_STOP;
            LK_RSTART: begin lk_next = LK_CTRLR; tx_next = ctrl_r; end
            LK_CTRLR:  lk_next = ack_ok_reg ? LK_READ : LK_STOP;
            LK_READ:   lk_next = read_last ? LK_STOP : LK_READ;
            LK_STOP:   lk_next = LK_IDLE;
            default:   lk_next = LK_IDLE;
        endcase
    end

    // Quarter 0 sets data, 1 raises the clock, 2 samples, 3 lowers the clock (left high in a stop) and steps.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            lk_reg <= LK_IDLE;  q_reg <= 2'h0;  qcnt_reg <= '0;  bit_reg <= 4'h0;
            tx_reg <= 8'h00;  rx_reg <= 8'h00;  ack_ok_reg <= 1'b0;
            rem_reg <= 10'h0;  bcnt_reg <= 10'h0;  txn_done_reg <= 1'b0;  txn_nack_reg <= 1'b0;
            byte_stb_reg <= 1'b0;  sda_oe <= 1'b0;  scl_oe <= 1'b0;
            sda_out_reg <= 1'b0;  scl_out_reg <= 1'b0;
        end else begin
            txn_done_reg <= 1'b0;
            byte_stb_reg <= 1'b0;
            if (lk_reg == LK_IDLE) begin
                qcnt_reg <= qtr_load;
                q_reg    <= 2'h0;
                bit_reg  <= 4'h0;
                if (go_reg) begin
                    lk_reg       <= LK_START;
                    rem_reg      <= job_len_reg;
                    bcnt_reg     <= 10'h0;
                    txn_nack_reg <= 1'b0;
                end
            end else if (qcnt_reg != '0) begin
                qcnt_reg <= qcnt_reg - QTR_W'(1);
            end else begin
                qcnt_reg <= qtr_load;
                q_reg    <= q_reg + 2'h1;
                unique case (q_reg)
                    2'h0: sda_oe <= sda_drive;
                    2'h1: scl_oe <= 1'b0;
                    2'h2: begin
                        // Start pulls data low under a high clock, stop releases it.
                        if (lk_reg == LK_START || lk_reg == LK_RSTART) sda_oe <= 1'b1;
                        if (lk_reg == LK_STOP) sda_oe <= 1'b0;
                        if (bit_reg == ACK_BIT) ack_ok_reg <= !sda_sync_reg;
                        else if (lk_reg == LK_READ) rx_reg <= {rx_reg[6:0], sda_sync_reg};
                    end
                    2'h3: begin
                        scl_oe <= (lk_reg != LK_STOP);
                        if ((is_wr || lk_reg == LK_READ) && bit_reg != ACK_BIT) begin
                            bit_reg <= bit_reg + 4'h1;
                            tx_reg  <= {tx_reg[6:0], 1'b0};
                        end else begin
                            lk_reg  <= lk_next;
                            tx_reg  <= tx_next;
                            bit_reg <= 4'h0;
                            if (is_wr) txn_nack_reg <= !ack_ok_reg;
                            if (lk_reg == LK_STOP) txn_done_reg <= 1'b1;
                            if (lk_reg == LK_READ) begin
                                byte_stb_reg <= 1'b1;
                                bcnt_reg     <= bcnt_reg + 10'h1;
                                rem_reg      <= rem_new;
                            end
                        end
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Loader sequence: detect, probe, scan, content copy.
    logic [5:0]        slot_reg;                  // Scan slot index.
    logic [7:0]        rec_mem [REC_BYTES];       // Record bytes of the current slot.
    logic [31:0]       timer_reg;                 // Settle and probe time-out counter.
    logic              found_reg;                 // A matching record was read.
    logic [4:0]        loaded_station_reg;
    logic [15:0]       ptr_reg;
    logic [1:0]        ent_ph_reg;                // Byte within a three-byte entry.
    logic [7:0]        ent_hi_reg;
    wire  [3:0]        stride_shift = 4'(STRIDE_BASE_SHIFT) + {2'h0, st_size} +
                                      (st_mode ? 4'(MODE16_SHIFT) : 4'h0);       // see R7
    wire  [15:0]       next_slot_addr = 16'(slot_reg + 6'h1) << stride_shift;
    wire               sig_ok = rec_mem[0] == SIG_0 && rec_mem[1] == SIG_1 &&
                                rec_mem[2] == SIG_2 && rec_mem[3] == SIG_3;       // see R6
    wire               id_ok  = rec_mem[OFS_REC_ID] == {5'h00, st_id};          // see R10
    wire  [15:0]       rec_ptr = {rec_mem[OFS_PTR_HI], rec_mem[OFS_PTR_LO]};
    wire  [2:0]        rec_idx = 3'(bcnt_reg - 10'h1);

    // Each outcome ends in done; done is never left, so no read follows it.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ld_reg <= LD_DETECT;  go_reg <= 1'b0;  job_addr_reg <= 16'h0000;  job_len_reg <= 10'h0;
            slot_reg <= 6'h00;  timer_reg <= 32'h0;  found_reg <= 1'b0;  loaded_station_reg <= 5'h00;
            ptr_reg <= 16'h0000;  ent_ph_reg <= 2'h0;  ent_hi_reg <= 8'h00;  strap_reg <= '0;
            eeprom_present <= 1'b0;  load_done <= 1'b0;  station_address <= 5'h00;
            cfg_wr_valid <= 1'b0;  cfg_wr_addr <= 8'h00;  cfg_wr_data <= 16'h0000;  fw_hold <= 1'b1;
            for (int i = 0; i < REC_BYTES; i++) rec_mem[i] <= 8'h00;
        end else begin
            go_reg       <= 1'b0;
            cfg_wr_valid <= 1'b0;
            if (byte_stb_reg && ld_reg == LD_SCAN) rec_mem[rec_idx] <= rx_reg;
            unique case (ld_reg)
                LD_DETECT: begin
                    timer_reg <= timer_reg + 32'h1;
                    if (timer_reg == 32'(DETECT_CYC - 1)) begin
                        strap_reg <= strap_sync_reg;
                        timer_reg <= 32'h0;
                        // A tied-low line means no memory and no access at all.
                        ld_reg    <= sda_sync_reg ? LD_PROBE : LD_DONE;  // see R1 see R2
                        go_reg    <= sda_sync_reg;                       // see R15
                        job_addr_reg <= 16'h0000;
                        job_len_reg  <= 10'h1;                           // see R4
                    end
                end
                LD_PROBE: begin
                    timer_reg <= timer_reg + 32'h1;
                    if (txn_done_reg) begin
                        if (!txn_nack_reg) begin
                            eeprom_present <= 1'b1;
                            ld_reg       <= LD_SCAN;
                            go_reg       <= 1'b1;
                            slot_reg     <= 6'h00;
                            job_len_reg  <= 10'(REC_BYTES);
                        end else if (timer_reg >= 32'(PROBE_TIMEOUT)) begin
                            ld_reg <= LD_DONE;                           // see R4 see R5 see R19
                        end else begin
                            go_reg <= 1'b1;  // Retry while the memory may still be busy.
                        end
                    end
                end
                LD_SCAN: begin
                    if (txn_done_reg) begin
                        if (txn_nack_reg) begin
                            ld_reg <= LD_DONE;
                        end else if (sig_ok && id_ok) begin
                            found_reg          <= 1'b1;
                            loaded_station_reg <= rec_mem[OFS_STATION][4:0];  // see R11
                            ptr_reg            <= rec_ptr;
                            ld_reg       <= (rec_ptr == NO_CONTENT) ? LD_DONE : LD_CONTENT;  // see R13
                            go_reg       <= (rec_ptr != NO_CONTENT);
                            job_addr_reg <= rec_ptr;
                            job_len_reg  <= 10'h1;
                        end else if (slot_reg == LAST_SLOT) begin
                            ld_reg <= LD_DONE;                                // see R8
                        end else begin
                            slot_reg     <= slot_reg + 6'h1;
                            job_addr_reg <= next_slot_addr;                   // see R7
                            go_reg       <= 1'b1;
                        end
                    end
                end
                LD_CONTENT: begin
                    // Entries go out as address, then high, then low data byte.
                    if (byte_stb_reg && bcnt_reg != 10'h1) begin
                        ent_ph_reg <= (ent_ph_reg == 2'h2) ? 2'h0 : ent_ph_reg + 2'h1;
                        if (ent_ph_reg == 2'h0) cfg_wr_addr <= rx_reg;        // see R17
                        if (ent_ph_reg == 2'h1) ent_hi_reg <= rx_reg;
                        if (ent_ph_reg == 2'h2) begin
                            cfg_wr_data  <= {ent_hi_reg, rx_reg};
                            cfg_wr_valid <= 1'b1;                             // see R15
                        end
                    end
                    if (txn_done_reg) ld_reg <= LD_DONE;
                end
                LD_DONE: begin
                    // The controller stays held until the whole copy is in.
                    fw_hold         <= 1'b0;                                  // see R16
                    load_done       <= 1'b1;
                    station_address <= found_reg ? loaded_station_reg : {2'h0, st_id};  // see R9 see R12
                end
                default: ld_reg <= LD_DONE;
            endcase
        end
    end

    // Open-drain pins only ever drive low.
    assign sda_out = sda_out_reg;
    assign scl_out = scl_out_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    no_mem_quiet_a: assert property ((ld_reg == LD_DONE && !eeprom_present) |-> !sda_oe && !scl_oe) // see R1
        else $error("Bus driven with no memory fitted.");
    station_zero_a: assert property (!load_done |-> station_address == 5'h00) // see R9
        else $error("Station address changed before load end.");
    default_addr_a: assert property ($rose(load_done) && !found_reg |-> station_address == {2'h0, st_id}) // see R12
        else $error("Default station address wrong.");
    loaded_addr_a: assert property ($rose(load_done) && found_reg |-> station_address == loaded_station_reg) // see R11
        else $error("Loaded station address not adopted.");
    match_id_a: assert property ($rose(found_reg) |-> $past(id_ok) && $past(sig_ok)) // see R10
        else $error("Record taken without signature and ID match.");
    stride_align_a: assert property (go_reg && ld_reg == LD_SCAN |-> (job_addr_reg & ((16'h1 << stride_shift) - 16'h1)) == 16'h0) // see R7
        else $error("Scan address off the stride.");
    no_content_a: assert property (ld_reg != LD_CONTENT ##1 ld_reg == LD_CONTENT |-> ptr_reg != NO_CONTENT) // see R13
        else $error("Content read with all-ones pointer.");
    done_final_a: assert property (ld_reg == LD_DONE |=> ld_reg == LD_DONE && !go_reg) // see R8
        else $error("Memory access after loader finished.");
    slave_addr_a: assert property (lk_reg == LK_START ##1 lk_reg == LK_CTRLW |-> tx_reg[7:4] == SLAVE_FIXED) // see R18
        else $error("Wrong fixed slave address bits.");
    hold_copy_a: assert property (cfg_wr_valid |-> fw_hold) // see R16
        else $error("Content written after controller release.");
endmodule // ebcl_loader
`default_nettype wire

// [rtl/ebcl_pkg.sv]
// Constants and types shared by the EEPROM boot configuration loader.
`default_nettype none
package ebcl_pkg;
    localparam int CLK_PERIOD_NS = 40;     // Core clock period.
    localparam int CLK_KHZ       = 25000;  // Core clock rate.
    localparam int SCL_STD_KHZ   = 100;
    localparam int SCL_FAST_KHZ  = 400;
    localparam int SCL_MEGA_KHZ  = 1000;
    localparam int SCL_HIGH_KHZ  = 3400;
    localparam logic [1:0] SPEED_STD  = 2'h0;
    localparam logic [1:0] SPEED_FAST = 2'h2;
    localparam logic [1:0] SPEED_MEGA = 2'h1;
    localparam logic [1:0] SPEED_HIGH = 2'h3;
    localparam int QTR_W = 8;  // Width of the quarter-bit counter.
    // A serial bit is four quarters; a quarter never runs shorter than asked.
    function automatic int qtr_cycles(input int khz);
        return (CLK_KHZ + 4 * khz - 1) / (4 * khz);
    endfunction
    localparam int DETECT_SETTLE_NS  = 1000;   // Pull-up settle time before sensing.
    localparam int DETECT_CYC        = (DETECT_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PROBE_TIMEOUT_US  = 10000;  // Acknowledge wait for the probe read.
    localparam int PROBE_TIMEOUT_CYC = PROBE_TIMEOUT_US * (CLK_KHZ / 1000);
    localparam logic [3:0] SLAVE_FIXED = 4'ha;  // Fixed upper slave address bits.
    localparam logic [7:0] SIG_0 = 8'hee;
    localparam logic [7:0] SIG_1 = 8'hc0;
    localparam logic [7:0] SIG_2 = 8'hde;
    localparam logic [7:0] SIG_3 = 8'h1f;
    localparam int REC_BYTES   = 8;  // Record bytes fetched at each scan slot.
    localparam int OFS_REC_ID  = 4;
    localparam int OFS_STATION = 5;
    localparam int OFS_PTR_HI  = 6;
    localparam int OFS_PTR_LO  = 7;
    localparam logic [15:0] NO_CONTENT = 16'hffff;
    localparam logic [5:0] LAST_SLOT = 6'h3f;  // Range divided into 64 slots.
    localparam int STRIDE_BASE_SHIFT = 2;       // Smallest range 256 bytes, stride 4.
    localparam int MODE16_SHIFT = 4;            // Wide address mode ranges are 16 times larger.
    localparam int ENTRY_BYTES  = 3;
    localparam logic [3:0] ACK_BIT = 4'h8;
    typedef enum logic [3:0] {
        LK_IDLE = 4'h0, LK_START = 4'h1, LK_CTRLW = 4'h3, LK_ADRH = 4'h2, LK_ADRL = 4'h6,
        LK_RSTART = 4'h7, LK_CTRLR = 4'h5, LK_READ = 4'h4, LK_STOP = 4'hc
    } ebcl_lk_e;
    typedef enum logic [2:0] {
        LD_DETECT = 3'h0, LD_PROBE = 3'h1, LD_SCAN = 3'h3, LD_CONTENT = 3'h2, LD_DONE = 3'h6
    } ebcl_ld_e;
endpackage
`default_nettype wire
